// ### shared/tlsl_pkg.sv
// constants, register map and types of the link supervision and led block
package tlsl_pkg;
	localparam int CLK_MHZ = 125;
	// timing in its own unit
	localparam int HB_MIN_BT = 5;
	localparam int HB_MAX_BT = 15;
	localparam int BT_NS = 100;
	localparam int CYC_NS = 8;
	localparam int HB_CYC = (HB_MIN_BT * BT_NS + CYC_NS - 1) / CYC_NS;
	localparam int RXTO_MIN_MS = 96;
	localparam int RXTO_CYC = RXTO_MIN_MS * CLK_MHZ * 1000;
	localparam int LAMP_MS = 1000;
	localparam int LAMP_CYC = LAMP_MS * CLK_MHZ * 1000;
	localparam int LINK_LOSS_MS = 100;
	localparam int LINK_LOSS_CYC = LINK_LOSS_MS * CLK_MHZ * 1000;
	localparam int JAB_MS = 20;
	localparam int JAB_CYC = JAB_MS * CLK_MHZ * 1000;
	localparam int UNJAB_MS = 500;
	localparam int UNJAB_CYC = UNJAB_MS * CLK_MHZ * 1000;
	localparam int ST30_MS = 30;
	localparam int ST60_MS = 60;
	localparam int ST100_MS = 100;
	localparam int ST30_CYC = ST30_MS * CLK_MHZ * 1000;
	localparam int ST60_CYC = ST60_MS * CLK_MHZ * 1000;
	localparam int ST100_CYC = ST100_MS * CLK_MHZ * 1000;
	localparam int TW = 28;
	// polarity thresholds
	localparam logic [3:0] POL_PULSES = 4'h8;
	localparam logic [3:0] POL_EOFS = 4'h4;
	// register byte offsets
	localparam logic [7:0] A_CFG = 8'h40;
	localparam logic [7:0] A_STAT1 = 8'h04;
	localparam logic [7:0] A_STAT2 = 8'h44;
	localparam logic [7:0] A_PAGE = 8'h18;
	localparam logic [7:0] A_LED = 8'h50;
	// field positions
	localparam int B_NOLIT = 14;
	localparam int B_JABOFF = 10;
	localparam int B_HB = 9;
	localparam int B_ALTNP = 1;
	localparam int B_LINK1 = 2;
	localparam int B_SPD = 14;
	localparam int B_LINK2 = 10;
	localparam int B_DPX = 9;
	localparam int B_ANDONE = 7;
	localparam int B_POL = 5;
	localparam int B_PGRX = 1;
	localparam int B_BASE = 5;
	localparam int B_STR_EN = 1;
	localparam int B_STR_LO = 2;
	localparam int LED_SEL_W = 4;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] LED_RST = 32'h0000_0000;
	// led sources
	localparam logic [3:0] LS_SPD = 4'h0;
	localparam logic [3:0] LS_TX = 4'h1;
	localparam logic [3:0] LS_RX = 4'h2;
	localparam logic [3:0] LS_COL = 4'h3;
	localparam logic [3:0] LS_LINK = 4'h4;
	localparam logic [3:0] LS_DPX = 4'h5;
	localparam logic [3:0] LS_ACT = 4'h7;
	localparam logic [3:0] LS_LNKACT = 4'hD;
	localparam logic [3:0] LS_OFF = 4'hE;
	localparam logic [3:0] LS_ON = 4'hF;
	localparam logic [1:0] SS_30 = 2'h0;
	localparam logic [1:0] SS_60 = 2'h1;
	localparam logic [1:0] SS_100 = 2'h2;
	typedef enum logic [1:0]
	{
		LK_DOWN = 2'b00,
		LK_UP   = 2'b01,
		LK_JAB  = 2'b10
	} tlsl_lk_t;
endpackage

// ### hw/tlsl_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module tlsl_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] m_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			m_q <= '0;
			q <= '0;
		end
		else
		begin
			m_q <= d;
			q <= m_q;
		end
	end
endmodule
`default_nettype wire

// ### hw/tlsl_stretch.sv
// led pulse stretcher with retriggering edge detector
`timescale 1ns/1ns
`default_nettype none
module tlsl_stretch #(
	parameter int TW = 28
) (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// control
	input  wire logic          enable,
	input  wire logic [TW-1:0] len,
	input  wire logic          event_in,
	output logic               led
);
	logic          seen_q;
	logic [TW-1:0] cnt_q;
	logic          edge_s;

	assign edge_s = event_in && !seen_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			seen_q <= 1'b0;
			cnt_q <= '0;
		end
		else if (edge_s)
		begin
			seen_q <= 1'b1;
			cnt_q <= len;
		end
		else if (cnt_q == TW'(1))
		begin
			seen_q <= event_in;
			cnt_q <= event_in ? len : '0;
		end
		else
		begin
			seen_q <= event_in;
			if (cnt_q != '0)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	assign led = enable ? (cnt_q != '0) : event_in;
endmodule
`default_nettype wire

// ### hw/tlsl_top.sv
// 10base-t link supervision, status bits and led drivers with apb registers
`timescale 1ns/1ns
`default_nettype none
module tlsl_top
	import tlsl_pkg::*;
#(
	parameter int RXTO_CYCLES = tlsl_pkg::RXTO_CYC,
	parameter int LAMP_CYCLES = tlsl_pkg::LAMP_CYC,
	parameter int LOSS_CYCLES = tlsl_pkg::LINK_LOSS_CYC,
	parameter int JAB_CYCLES = tlsl_pkg::JAB_CYC,
	parameter int UNJAB_CYCLES = tlsl_pkg::UNJAB_CYC,
	parameter int S30_CYCLES = tlsl_pkg::ST30_CYC,
	parameter int S60_CYCLES = tlsl_pkg::ST60_CYC,
	parameter int S100_CYCLES = tlsl_pkg::ST100_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// line receive events from the analog front end
	input  wire logic        rx_link_pulse,
	input  wire logic        rx_pulse_inv,
	input  wire logic        rx_eof,
	input  wire logic        rx_eof_inv,
	input  wire logic        rx_data,
	// mac and mode
	input  wire logic        tx_en,
	input  wire logic        col_in,
	input  wire logic        mode_10m,
	input  wire logic        full_duplex,
	input  wire logic        an_enable,
	input  wire logic        an_done,
	input  wire logic        an_start,
	input  wire logic        page_rx,
	input  wire logic        page_is_base,
	// line side control
	output logic             link_pulse_en,
	output logic             tx_allow,
	output logic             loopback_allow,
	output logic             an_restart,
	output logic             col_out,
	output logic             rx_invert,
	// led drivers
	output logic             indicator_pin_one,
	output logic             indicator_pin_two,
	output logic             indicator_pin_three
);
	import tlsl_pkg::*;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [4:0] ln_s;
	logic       lp_s, lpi_s, eof_s, eofi_s, rxd_s;
	logic       lp_p_q, lpi_p_q, eof_p_q, eofi_p_q;
	logic       lp_e, lpi_e, eof_e, eofi_e;

	tlsl_sync #(.W(5)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({rx_link_pulse, rx_pulse_inv, rx_eof, rx_eof_inv, rx_data}),
		.q       (ln_s)
	);
	assign {lp_s, lpi_s, eof_s, eofi_s, rxd_s} = ln_s;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lp_p_q <= 1'b0;
			lpi_p_q <= 1'b0;
			eof_p_q <= 1'b0;
			eofi_p_q <= 1'b0;
		end
		else
		begin
			lp_p_q <= lp_s;
			lpi_p_q <= lpi_s;
			eof_p_q <= eof_s;
			eofi_p_q <= eofi_s;
		end
	end
	assign lp_e = lp_s && !lp_p_q;
	assign lpi_e = lpi_s && !lpi_p_q;
	assign eof_e = eof_s && !eof_p_q;
	assign eofi_e = eofi_s && !eofi_p_q;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [31:0] cfg_q, led_q;
	logic        rd_s, wr_s;
	logic        pg_rx_q, base_q;

	assign wr_s = psel && penable && pwrite;
	assign rd_s = psel && penable && !pwrite;
	assign pready = 1'b1;

	function automatic logic known(input logic [7:0] a);
		known = (a == A_CFG) || (a == A_STAT1) || (a == A_STAT2)
			|| (a == A_PAGE) || (a == A_LED);
	endfunction

	assign pslverr = psel && penable && !known(paddr);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_q <= CFG_RST;
			led_q <= LED_RST;
		end
		else if (wr_s && paddr == A_CFG)
			cfg_q <= pwdata;
		else if (wr_s && paddr == A_LED)
			led_q <= pwdata;
	end

	// ----------------------------------------
	// link integrity and jabber
	// ----------------------------------------
	tlsl_lk_t    lk_q;
	logic [TW:0] loss_q, jab_q;
	logic        no_lit, rx_act;

	assign no_lit = cfg_q[B_NOLIT];
	assign rx_act = lp_e || rxd_s;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			loss_q <= '0;
		else if (rx_act)
			loss_q <= (TW+1)'(LOSS_CYCLES);
		else if (loss_q != '0)
			loss_q <= loss_q - 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lk_q <= LK_DOWN;
			jab_q <= '0;
		end
		else
		begin
			unique case (lk_q)
				LK_DOWN:
				begin
					if (lp_e)
						lk_q <= LK_UP;
					if (tx_en && !cfg_q[B_JABOFF] && jab_q == (TW+1)'(JAB_CYCLES))
					begin
						lk_q <= LK_JAB;
						jab_q <= '0;
					end
					else
						jab_q <= tx_en ? jab_q + 1'b1 : '0;
				end
				LK_UP:
				begin
					if (loss_q == '0 && !rx_act)
						lk_q <= LK_DOWN;
					else if (tx_en && !cfg_q[B_JABOFF] && jab_q == (TW+1)'(JAB_CYCLES))
					begin
						lk_q <= LK_JAB;
						jab_q <= '0;
					end
					else
						jab_q <= tx_en ? jab_q + 1'b1 : '0;
				end
				LK_JAB:
				begin
					if (cfg_q[B_JABOFF] || jab_q == (TW+1)'(UNJAB_CYCLES))
					begin
						lk_q <= (loss_q != '0) ? LK_UP : LK_DOWN;
						jab_q <= '0;
					end
					else
						jab_q <= jab_q + 1'b1;
				end
				default:
					lk_q <= LK_DOWN;
			endcase
		end
	end

	logic link_up;
	assign link_up = (lk_q == LK_UP) || (lk_q == LK_JAB && loss_q != '0);
	assign link_pulse_en = mode_10m;
	assign tx_allow = (lk_q == LK_UP) || (no_lit && lk_q != LK_JAB);
	assign loopback_allow = (lk_q != LK_JAB);
	assign an_restart = an_enable && !no_lit && lk_q == LK_UP && loss_q == '0 && !rx_act;

	// ----------------------------------------
	// heartbeat
	// ----------------------------------------
	logic       txd_q;
	logic [7:0] hb_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			txd_q <= 1'b0;
			hb_q <= '0;
		end
		else
		begin
			txd_q <= tx_en;
			if (txd_q && !tx_en && cfg_q[B_HB] && mode_10m)
				hb_q <= 8'(HB_CYC);
			else if (hb_q != '0)
				hb_q <= hb_q - 1'b1;
		end
	end
	assign col_out = col_in || (hb_q != '0);

	// ----------------------------------------
	// polarity
	// ----------------------------------------
	logic [3:0]  pinv_q, einv_q;
	logic [TW:0] rxto_q;
	logic        inv_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pinv_q <= '0;
			einv_q <= '0;
			inv_q <= 1'b0;
			rxto_q <= '0;
		end
		else
		begin
			if (rx_act || eof_e || eofi_e || lpi_e)
				rxto_q <= (TW+1)'(RXTO_CYCLES);
			else if (rxto_q != '0)
				rxto_q <= rxto_q - 1'b1;
			if (lp_e)
				pinv_q <= '0;
			else if (lpi_e)
				pinv_q <= pinv_q + 1'b1;
			if (eof_e)
				einv_q <= '0;
			else if (eofi_e)
				einv_q <= einv_q + 1'b1;
			if (pinv_q == POL_PULSES || einv_q == POL_EOFS)
			begin
				inv_q <= 1'b1;
				pinv_q <= '0;
				einv_q <= '0;
			end
			else if (rxto_q == (TW+1)'(1) && !(rx_act || lpi_e || eofi_e || eof_e))
				inv_q <= 1'b0;
		end
	end
	assign rx_invert = inv_q;

	// ----------------------------------------
	// page bits
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pg_rx_q <= 1'b0;
			base_q <= 1'b0;
		end
		else
		begin
			if (page_rx)
				pg_rx_q <= 1'b1;
			else if ((rd_s && paddr == A_PAGE) || (an_start && cfg_q[B_ALTNP]))
				pg_rx_q <= 1'b0;
			if (page_rx && page_is_base)
				base_q <= 1'b1;
			else if (rd_s && paddr == A_PAGE)
				base_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [31:0] rd_d;
	always_comb
	begin
		rd_d = '0;
		unique case (paddr)
			A_CFG: rd_d = cfg_q;
			A_LED: rd_d = led_q;
			A_STAT1: rd_d[B_LINK1] = link_up;
			A_STAT2:
			begin
				rd_d[B_LINK2] = link_up;
				rd_d[B_SPD] = !mode_10m;
				rd_d[B_DPX] = full_duplex;
				rd_d[B_ANDONE] = an_done;
				rd_d[B_POL] = inv_q && mode_10m;
			end
			A_PAGE:
			begin
				rd_d[B_PGRX] = pg_rx_q;
				rd_d[B_BASE] = base_q;
			end
			default: rd_d = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_d;
	end

	// ----------------------------------------
	// leds
	// ----------------------------------------
	logic [TW-1:0] lamp_q, slen;
	logic [2:0]    led_s;
	logic          act_s;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lamp_q <= TW'(LAMP_CYCLES);
		else if (lamp_q != '0)
			lamp_q <= lamp_q - 1'b1;
	end

	assign slen = (led_q[B_STR_LO+1:B_STR_LO] == SS_30) ? TW'(S30_CYCLES)
		: (led_q[B_STR_LO+1:B_STR_LO] == SS_60) ? TW'(S60_CYCLES)
		: TW'(S100_CYCLES);
	assign act_s = tx_en || rxd_s;

	function automatic logic led_src(input logic [3:0] sel, input logic lk, input logic a);
		unique case (sel)
			LS_SPD:  led_src = !mode_10m;
			LS_TX:   led_src = tx_en;
			LS_RX:   led_src = rxd_s;
			LS_COL:  led_src = col_out;
			LS_LINK: led_src = lk;
			LS_DPX:  led_src = full_duplex;
			LS_ACT:  led_src = a;
			LS_LNKACT: led_src = lk ^ a;
			LS_ON:   led_src = 1'b1;
			default: led_src = 1'b0;
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_led
			logic lv;
			tlsl_stretch #(.TW(TW)) u_str (
				.pclk     (pclk),
				.presetn  (presetn),
				.enable   (led_q[B_STR_EN]),
				.len      (slen),
				.event_in (led_src(led_q[LED_SEL_W*4-1-LED_SEL_W*gi -: LED_SEL_W], link_up, act_s)),
				.led      (lv)
			);
			assign led_s[gi] = (lamp_q != '0) || lv;
		end
	endgenerate

	assign indicator_pin_one = led_s[0];
	assign indicator_pin_two = led_s[1];
	assign indicator_pin_three = led_s[2];
endmodule
`default_nettype wire

// ### sim/tlsl_monitor.sv
// assertion checker for the link supervision and led block
`timescale 1ns/1ns
`default_nettype none
module tlsl_monitor #(
	parameter int LAMP_CYCLES = 100,
	parameter int JAB_CYCLES  = 80,
	parameter int RXTO_CYCLES = 200
) (
	// clock, reset, apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	// line and mac
	input wire logic        rx_link_pulse,
	input wire logic        rx_pulse_inv,
	input wire logic        rx_eof_inv,
	input wire logic        tx_en,
	input wire logic        col_in,
	input wire logic        mode_10m,
	// outputs
	input wire logic        link_pulse_en,
	input wire logic        tx_allow,
	input wire logic        loopback_allow,
	input wire logic        col_out,
	input wire logic        rx_invert,
	input wire logic        indicator_pin_one,
	input wire logic        indicator_pin_two,
	input wire logic        indicator_pin_three
);
	import tlsl_pkg::*;
	logic [31:0] cfg_q;
	logic [31:0] lamp_q;
	logic [31:0] run_q;
	logic [31:0] idle_q;
	logic [3:0]  inv_q;
	logic [3:0]  eofi_q;
	logic        hb_q;
	logic        mapped;
	assign mapped = paddr inside {A_CFG, A_STAT1, A_STAT2, A_PAGE, A_LED};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_q <= CFG_RST;
			hb_q <= 1'h0;
			lamp_q <= 32'h0;
			run_q <= 32'h0;
			idle_q <= 32'h0;
			inv_q <= 4'h0;
			eofi_q <= 4'h0;
		end
		else
		begin
			if (psel && penable && pwrite && paddr == A_CFG)
				cfg_q <= pwdata;
			hb_q <= hb_q | cfg_q[B_HB];
			lamp_q <= lamp_q + 32'(lamp_q < LAMP_CYCLES);
			run_q <= tx_en ? run_q + 32'h1 : 32'h0;
			idle_q <= (rx_link_pulse | rx_pulse_inv | rx_eof_inv) ? 32'h0 : idle_q + 32'h1;
			inv_q <= $rose(rx_link_pulse) ? 4'h0 : inv_q + 4'($rose(rx_pulse_inv) && inv_q != 4'hF);
			eofi_q <= eofi_q + 4'($rose(rx_eof_inv) && eofi_q != 4'hF);
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pulse_always: assert property (link_pulse_en == mode_10m)
		else $error("link pulse enable wrong");
	a_link_up: assert property ($rose(rx_link_pulse) && !tx_en |-> ##[1:5] tx_allow)
		else $error("transmit not enabled by pulse");
	a_nolit_tx: assert property ($rose(cfg_q[B_NOLIT]) |-> ##[1:3] tx_allow)
		else $error("override did not allow transmit");
	a_hb_on: assert property ($fell(tx_en) && cfg_q[B_HB] && mode_10m |-> ##[1:4] col_out [*8])
		else $error("heartbeat missing");
	a_hb_off: assert property (!hb_q && !col_in |-> !col_out)
		else $error("heartbeat while off");
	a_jab_block: assert property (run_q > JAB_CYCLES + 6 && run_q < JAB_CYCLES + 30
		&& !cfg_q[B_JABOFF] |-> !tx_allow && !loopback_allow)
		else $error("jabber did not block");
	a_pol_count: assert property ($rose(rx_invert) |-> inv_q >= POL_PULSES || eofi_q >= POL_EOFS)
		else $error("polarity flipped early");
	a_pol_timeout: assert property (idle_q > RXTO_CYCLES + 8 |-> !rx_invert)
		else $error("polarity not reset");
	a_lamp_all: assert property (lamp_q < LAMP_CYCLES - 2
		|-> indicator_pin_one && indicator_pin_two && indicator_pin_three)
		else $error("lamp test off");
	a_bad_addr: assert property (psel && penable |-> pslverr == !mapped)
		else $error("slave error wrong");
	c_pol: cover property ($rose(rx_invert));
	c_hb: cover property ($rose(col_out) && hb_q);
	c_err: cover property (pslverr);
endmodule
bind tlsl_top tlsl_monitor #(
	.LAMP_CYCLES(LAMP_CYCLES),
	.JAB_CYCLES(JAB_CYCLES),
	.RXTO_CYCLES(RXTO_CYCLES)
) i_tlsl_monitor (.*);
`default_nettype wire

// ### sim/tlsl_line_model.sv
// link partner model making receive line events
`timescale 1ns/1ns
`default_nettype none
module tlsl_line_model #(
	parameter int PERIOD = 30
) (
	// clock and mode: 0 silent, 1 pulses, 2 inverted pulses, 3 inverted eofs
	input  wire logic       pclk,
	input  wire logic [1:0] mode,
	// receive events
	output logic            rx_link_pulse,
	output logic            rx_pulse_inv,
	output logic            rx_eof_inv
);
	int n = 0;
	initial {rx_link_pulse, rx_pulse_inv, rx_eof_inv} = 3'h0;
	always @(posedge pclk)
	begin
		n <= (n + 1) % PERIOD;
		rx_link_pulse <= mode == 2'h1 && n < 2;
		rx_pulse_inv <= mode == 2'h2 && n < 2;
		rx_eof_inv <= mode == 2'h3 && n < 2;
	end
endmodule
`default_nettype wire

// ### sim/tenbaset_link_status_led_bench.sv
// self-checking bench for the link supervision and led block
`timescale 1ns/1ns
`default_nettype none
module tenbaset_link_status_led_bench;
	import tlsl_pkg::*;
	localparam int LAMP = 100;
	localparam int JAB = 80;
	localparam int UNJAB = 100;
	localparam int RXTO = 200;
	localparam int S100 = 90;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic tx_en, col_in, mode_10m, full_duplex, an_enable, an_done, an_start, page_rx;
	logic page_is_base, rx_eof, rx_data, rx_link_pulse, rx_pulse_inv, rx_eof_inv;
	logic link_pulse_en, tx_allow, loopback_allow, an_restart, col_out, rx_invert;
	logic indicator_pin_one, indicator_pin_two, indicator_pin_three;
	logic [1:0] lm;
	int failures = 0;
	int check_count = 0;
	int k, n, s;
	typedef struct {logic [3:0] sel; logic fd, tx, col, exp;} tlsl_row_t;
	tlsl_row_t rows [7] = '{'{LS_ON, 0, 0, 0, 1}, '{LS_OFF, 0, 0, 0, 0}, '{LS_DPX, 1, 0, 0, 1},
		'{LS_DPX, 0, 0, 0, 0}, '{LS_TX, 0, 1, 0, 1}, '{LS_TX, 0, 0, 0, 0}, '{LS_COL, 0, 0, 1, 1}};
	tlsl_top #(.RXTO_CYCLES(RXTO), .LAMP_CYCLES(LAMP), .LOSS_CYCLES(150), .JAB_CYCLES(JAB),
		.UNJAB_CYCLES(UNJAB), .S30_CYCLES(40), .S60_CYCLES(60), .S100_CYCLES(S100)) i_tlsl_top (.*);
	tlsl_line_model i_tlsl_line_model (.pclk, .mode(lm), .rx_link_pulse, .rx_pulse_inv, .rx_eof_inv);
	initial
	begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
		begin
			t++;
			if (t > 40)
			begin
				failures++;
				report_and_stop();
			end
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic lit(input int c);
		n = 0;
		repeat (c) @(posedge pclk) n += indicator_pin_one;
	endtask
	initial
	begin
		{psel, penable, pwrite, tx_en, col_in, full_duplex, an_done, an_start} = 8'h00;
		{page_rx, page_is_base, rx_eof, rx_data, presetn} = 5'h00;
		{an_enable, mode_10m, lm, paddr, pwdata} = {2'h3, 2'h0, 8'h00, 32'h0};
		cyc(2);
		check("lamp", {indicator_pin_one, indicator_pin_two, indicator_pin_three}, 3'h7);
		presetn <= 1'h1;
		apb(1'h0, A_CFG, 32'h0);
		check("cfg", rd, CFG_RST);
		cyc(LAMP + 10);
		for (k = 0; k < 7; k++)
		begin
			full_duplex <= rows[k].fd;
			tx_en <= rows[k].tx;
			col_in <= rows[k].col;
			apb(1'h1, A_LED, {16'h0, {3{rows[k].sel}}, 4'h0});
			cyc(4);
			check("row", {indicator_pin_one, indicator_pin_two, indicator_pin_three},
				{3{rows[k].exp}});
		end
		col_in <= 1'h0;
		lm <= 2'h1;
		an_done <= 1'h1;
		cyc(100);
		check("txa", tx_allow, 1'h1);
		apb(1'h0, A_STAT1, 32'h0);
		check("link1", rd[B_LINK1], 1'h1);
		apb(1'h0, A_STAT2, 32'h0);
		check("link2", rd[B_LINK2], 1'h1);
		check("andone", rd[B_ANDONE], 1'h1);
		check("spd_dpx", {rd[B_SPD], rd[B_DPX]}, 2'h0);
		check("pol", rd[B_POL], 1'h0);
		apb(1'h1, A_LED, {16'h0, {3{LS_LNKACT}}, 4'h0});
		cyc(4);
		check("lnkact", indicator_pin_one, 1'h1);
		apb(1'h1, A_CFG, 32'h1 << B_HB);
		tx_en <= 1'h1;
		cyc(5);
		tx_en <= 1'h0;
		s = 0;
		repeat (250) @(posedge pclk) s += col_out;
		check("hb", s >= HB_CYC && s <= HB_MAX_BT * BT_NS / CYC_NS + 2, 1'h1);
		lm <= 2'h0;
		s = 0;
		repeat (190) @(posedge pclk) s += an_restart;
		check("txa", tx_allow, 1'h0);
		check("anr", s != 0, 1'h1);
		check("lnkact", indicator_pin_one, 1'h0);
		for (k = 0; k < 2; k++)
		begin
			apb(1'h1, A_CFG, (32'h1 << B_NOLIT) | (32'(k) << B_JABOFF));
			cyc(3);
			check("nolit", tx_allow, 1'h1);
			tx_en <= 1'h1;
			cyc(JAB + 10);
			check("jab", {tx_allow, loopback_allow}, {2{k[0]}});
			tx_en <= 1'h0;
			cyc(UNJAB + 20);
			check("unjab", {tx_allow, loopback_allow}, 2'h3);
		end
		apb(1'h1, A_CFG, 32'h0);
		for (k = 2; k < 4; k++)
		begin
			lm <= 2'(k);
			cyc(320);
			check("inv", rx_invert, 1'h1);
			apb(1'h0, A_STAT2, 32'h0);
			check("pol", rd[B_POL], 1'h1);
			lm <= 2'h0;
			cyc(RXTO + 60);
			check("inv", rx_invert, 1'h0);
		end
		{page_rx, page_is_base} <= 2'h3;
		cyc(1);
		{page_rx, page_is_base} <= 2'h0;
		cyc(20);
		apb(1'h0, A_PAGE, 32'h0);
		check("page", {rd[B_BASE], rd[B_PGRX]}, 2'h3);
		apb(1'h0, A_PAGE, 32'h0);
		check("page", {rd[B_BASE], rd[B_PGRX]}, 2'h0);
		apb(1'h1, A_CFG, 32'h1 << B_ALTNP);
		page_rx <= 1'h1;
		cyc(1);
		{page_rx, an_start} <= 2'h1;
		cyc(1);
		an_start <= 1'h0;
		apb(1'h0, A_PAGE, 32'h0);
		check("altnp", rd[B_PGRX], 1'h0);
		for (k = 0; k < 3; k++)
		begin
			apb(1'h1, A_LED, {16'h0, {3{LS_TX}}, 2'(k), 2'h2});
			tx_en <= 1'h1;
			cyc(1);
			tx_en <= 1'h0;
			lit(S100 + 40);
			s = k == 0 ? 40 : k == 1 ? 60 : S100;
			check("str", n >= s - 2 && n <= s + 4, 1'h1);
		end
		tx_en <= 1'h1;
		cyc(1);
		tx_en <= 1'h0;
		cyc(29);
		tx_en <= 1'h1;
		cyc(1);
		tx_en <= 1'h0;
		lit(S100 + 40);
		check("retrig", n >= S100 - 2 && n <= S100 + 4, 1'h1);
		full_duplex <= 1'h1;
		apb(1'h1, A_LED, {16'h0, {3{LS_DPX}}, SS_30, 2'h2});
		cyc(1);
		lit(160);
		check("long", n, 160);
		full_duplex <= 1'h0;
		cyc(100);
		check("long", indicator_pin_one, 1'h0);
		apb(1'h0, 8'hFC, 32'h0);
		check("err", er, 1'h1);
		check("err_rd", rd, 32'h0);
		report_and_stop();
	end
	initial
	begin
		cyc(90000);
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
